/* File: verilog/charge_data_frame_packer.sv */
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module charge_data_frame_packer (
	// clock, reset, enable
	input  wire logic                                 i_sys_clk,
	input  wire logic                                 i_sys_rst,
	input  wire logic                                 i_clk_en,
	// apb slave
	input  wire logic                                 i_psel,
	input  wire logic                                 i_penable,
	input  wire logic                                 i_pwrite,
	input  wire logic [frame_pkg::ADDR_W-1:0]         i_paddr,
	input  wire logic [31:0]                          i_pwdata,
	output logic      [31:0]                          o_prdata,
	output logic                                      o_pready,
	output logic                                      o_pslverr,
	// integrator side pins
	input  wire logic                                 i_integration_clock,
	input  wire logic [frame_pkg::CHAN_W-1:0]         i_chan_data,
	input  wire logic [frame_pkg::CAP_W-1:0]          i_capacitor_index,
	input  wire logic                                 i_proton_mark,
	input  wire logic                                 i_pbar_mark,
	input  wire logic [frame_pkg::MODE_W-1:0]         i_int_mode,
	input  wire logic                                 i_data_valid,
	// serializer side
	input  wire logic                                 i_ser_clk,
	output logic      [frame_pkg::WORD_W-1:0]         o_ser_data,
	output logic                                      o_ser_ctrl
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	localparam int PIN_W = frame_pkg::ESS_W;
	logic [PIN_W-1:0] pin_lvl;
	logic [1:0]       clk_rise;
	logic             int_rise;
	logic             ser_rise;

	pin_sync #(.W(PIN_W)) u_data_sync (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.i_pin     ({i_proton_mark, i_pbar_mark, i_int_mode, i_data_valid,
		              i_capacitor_index, i_chan_data}),
		.o_level   (pin_lvl),
		.o_rise    ()
	);

	// both clocks sampled as pins: edges found here
	pin_sync #(.W(2)) u_clk_sync (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.i_pin     ({i_ser_clk, i_integration_clock}),
		.o_level   (),
		.o_rise    (clk_rise)
	);
	assign int_rise = clk_rise[0];
	assign ser_rise = clk_rise[1];

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic                                  ctrl_en;
		logic                                  ovf;
		logic                                  pend_v;
		logic [frame_pkg::PAY_W-1:0]           pend;
		logic [frame_pkg::PAY_W-1:0]           shift;
		frame_pkg::tx_state_t                  tx;
		logic [frame_pkg::WIDX_W-1:0]          widx;
		logic [frame_pkg::INTCNT_W-1:0]        int_cnt;
		logic [frame_pkg::SERCNT_W-1:0]        ser_cnt;
		logic [frame_pkg::CNT_W-1:0]           blk_cnt;
		logic [frame_pkg::CNT_W-1:0]           drop_cnt;
		logic [frame_pkg::WORD_W-1:0]          ser_data;
		logic                                  ser_ctrl;
		logic [31:0]                           prdata;
	} state_t;
	state_t q;
	state_t d;

	function automatic logic hit(input logic [frame_pkg::ADDR_W-1:0] a,
		input logic [frame_pkg::ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb
	begin
		logic wr;
		logic taken;
		wr = i_psel && i_penable && i_pwrite;
		taken = 1'b0;
		d = q;
		// apb read data latched in setup phase
		if (i_psel && !i_penable)
		begin
			d.prdata = '0;
			if (hit(i_paddr, frame_pkg::CTRL_OFS))
				d.prdata[frame_pkg::CTRL_EN_BIT] = q.ctrl_en;
			if (hit(i_paddr, frame_pkg::STATUS_OFS))
			begin
				d.prdata[frame_pkg::ST_OVF_BIT]  = q.ovf;
				d.prdata[frame_pkg::ST_BUSY_BIT] = (q.tx == frame_pkg::TX_SEND);
				d.prdata[frame_pkg::ST_PEND_BIT] = q.pend_v;
			end
			if (hit(i_paddr, frame_pkg::BLKCNT_OFS))
				d.prdata[frame_pkg::CNT_W-1:0] = q.blk_cnt;
			if (hit(i_paddr, frame_pkg::DROP_OFS))
				d.prdata[frame_pkg::CNT_W-1:0] = q.drop_cnt;
		end
		// apb writes, applied before events so a same-cycle set wins
		if (wr && hit(i_paddr, frame_pkg::CTRL_OFS))
		begin
			d.ctrl_en = i_pwdata[frame_pkg::CTRL_EN_BIT];
			if (i_pwdata[frame_pkg::CTRL_CLR_BIT])
			begin
				d.blk_cnt = '0;
				d.drop_cnt = '0;
			end
		end
		if (wr && hit(i_paddr, frame_pkg::STATUS_OFS) && i_pwdata[frame_pkg::ST_OVF_BIT])
			d.ovf = 1'b0;
		// serializer cadence: one word per serializer clock rising edge
		if (ser_rise)
		begin
			d.ser_cnt = q.ser_cnt + 1'b1;
			unique case (q.tx)
				frame_pkg::TX_IDLE:
				begin
					if (q.pend_v)
					begin
						d.ser_data = frame_pkg::START_CODE;
						d.ser_ctrl = 1'b1;
						d.shift = q.pend;
						d.pend_v = 1'b0;
						taken = 1'b1;
						d.widx = '0;
						d.tx = frame_pkg::TX_SEND;
					end
					else
					begin
						d.ser_data = frame_pkg::IDLE_CODE;
						d.ser_ctrl = 1'b1;
					end
				end
				frame_pkg::TX_SEND:
				begin
					d.ser_data = q.shift[frame_pkg::PAY_W-1 -: frame_pkg::WORD_W];
					d.ser_ctrl = 1'b0;
					d.shift = q.shift << frame_pkg::WORD_W;
					d.widx = q.widx + 1'b1;
					// fixed word count ends every block
					if (q.widx == frame_pkg::LAST_WORD)
					begin
						d.tx = frame_pkg::TX_IDLE;
						d.blk_cnt = d.blk_cnt + 1'b1;
					end
				end
			endcase
		end
		// capture on each integration clock rising edge while enabled, no queue behind it
		if (int_rise)
		begin
			d.int_cnt = q.int_cnt + 1'b1;
			if (q.ctrl_en)
			begin
				if (q.pend_v && !taken)
				begin
					d.ovf = 1'b1;
					d.drop_cnt = d.drop_cnt + 1'b1;
				end
				else
				begin
					d.pend_v = 1'b1;
					d.pend = {{frame_pkg::PAD_W{1'b0}}, q.ser_cnt, q.int_cnt,
					          pin_lvl};
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			q <= '0;
			q.ser_data <= frame_pkg::IDLE_CODE;
			q.ser_ctrl <= 1'b1;
		end
		else if (i_clk_en)
			q <= d;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_ser_data = q.ser_data;
	assign o_ser_ctrl = q.ser_ctrl;
	assign o_prdata   = q.prdata;
	assign o_pready   = i_clk_en;
	assign o_pslverr  = i_psel && i_penable && !(hit(i_paddr, frame_pkg::CTRL_OFS)
		|| hit(i_paddr, frame_pkg::STATUS_OFS) || hit(i_paddr, frame_pkg::BLKCNT_OFS)
		|| hit(i_paddr, frame_pkg::DROP_OFS));

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_sys_rst);

	logic go;
	assign go = i_clk_en && ser_rise;

	a_start_marker: assert property (go && q.tx == frame_pkg::TX_IDLE && q.pend_v
		|=> o_ser_ctrl && o_ser_data == frame_pkg::START_CODE && q.widx == '0)
		else $error("block not opened by start character");
	a_idle_fill: assert property (go && q.tx == frame_pkg::TX_IDLE && !q.pend_v
		|=> o_ser_ctrl && o_ser_data == frame_pkg::IDLE_CODE)
		else $error("gap not filled with idle");
	a_payload_word: assert property (go && q.tx == frame_pkg::TX_SEND
		|=> !o_ser_ctrl && o_ser_data == $past(q.shift[frame_pkg::PAY_W-1 -: frame_pkg::WORD_W]))
		else $error("payload word wrong");
	a_fixed_length: assert property (go && q.tx == frame_pkg::TX_SEND
		&& q.widx == frame_pkg::LAST_WORD |=> q.tx == frame_pkg::TX_IDLE)
		else $error("block length not fixed");
	a_capture_chan: assert property (i_clk_en && int_rise && q.ctrl_en && !q.pend_v
		|=> q.pend_v && q.pend[frame_pkg::CHAN_W-1:0] == $past(pin_lvl[frame_pkg::CHAN_W-1:0]))
		else $error("channel data not captured");
	a_shared_cap: assert property (i_clk_en && int_rise && q.ctrl_en && !q.pend_v
		|=> q.pend[frame_pkg::CAP_LSB +: frame_pkg::CAP_W]
		== $past(pin_lvl[frame_pkg::CAP_LSB +: frame_pkg::CAP_W]))
		else $error("capacitor index wrong");
	a_header_bits: assert property (i_clk_en && int_rise && q.ctrl_en && !q.pend_v
		|=> q.pend[frame_pkg::HDR_LSB +: frame_pkg::HDR_W]
		== $past(pin_lvl[frame_pkg::HDR_LSB +: frame_pkg::HDR_W]))
		else $error("header bits wrong");
	a_one_per_cycle: assert property ($rose(q.pend_v) |-> $past(int_rise))
		else $error("block loaded without integration edge");
	a_debug_count: assert property (i_clk_en && int_rise && q.ctrl_en && !q.pend_v
		|=> q.pend[frame_pkg::SPR_LSB +: frame_pkg::INTCNT_W] == q.int_cnt - 1'b1)
		else $error("debug counter wrong");

	c_block_sent: cover property (go && q.tx == frame_pkg::TX_SEND
		&& q.widx == frame_pkg::LAST_WORD);
	c_overflow: cover property ($rose(q.ovf));
	c_back_to_back: cover property (go && q.tx == frame_pkg::TX_IDLE && q.pend_v
		&& $past(q.tx == frame_pkg::TX_SEND));
endmodule
`default_nettype wire

/* File: verilog/frame_pkg.sv */
// Overview of operation
// - capture eight 7-bit channel values per cycle
// - one shared 2-bit capacitor index per block
// - five header bits: markers, mode, valid flag
// - 63 essential bits once per integration period
// - every block has identical fixed length
// - idle characters fill any gap between blocks
// - link latency skew under four integration cycles
// - sampling and serializing run on separate clocks
// - spare bits carry debug cycle counters
//
`default_nettype none
package frame_pkg;
	// ----------------------------------------
	// block layout
	// ----------------------------------------
	localparam int CH_NUM    = 8;
	localparam int CH_W      = 7;
	localparam int CHAN_W    = CH_NUM * CH_W;
	localparam int CAP_W     = 2;
	localparam int MODE_W    = 2;
	localparam int HDR_W     = 5;
	localparam int ESS_W     = CHAN_W + CAP_W + HDR_W;
	localparam int INTCNT_W  = 14;
	localparam int SERCNT_W  = 8;
	localparam int SPARE_W   = INTCNT_W + SERCNT_W;
	localparam int WORD_W    = 16;
	localparam int PAY_WORDS = 6;
	localparam int PAY_W     = WORD_W * PAY_WORDS;
	localparam int PAD_W     = PAY_W - ESS_W - SPARE_W;
	localparam int WIDX_W    = 3;
	localparam int CAP_LSB   = CHAN_W;
	localparam int HDR_LSB   = CAP_LSB + CAP_W;
	localparam int SPR_LSB   = ESS_W;
	localparam logic [WIDX_W-1:0] LAST_WORD = 3'h5;
	// ----------------------------------------
	// link characters
	// ----------------------------------------
	localparam logic [WORD_W-1:0] START_CODE = 16'h50BC;
	localparam logic [WORD_W-1:0] IDLE_CODE  = 16'hC5BC;
	// ----------------------------------------
	// register map (apb byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h000;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] BLKCNT_OFS = 12'h008;
	localparam logic [ADDR_W-1:0] DROP_OFS   = 12'h00C;
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam int ST_OVF_BIT   = 0;
	localparam int ST_BUSY_BIT  = 1;
	localparam int ST_PEND_BIT  = 2;
	localparam int CNT_W        = 16;
	// ----------------------------------------
	// transmit states
	// ----------------------------------------
	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} tx_state_t;
endpackage
`default_nettype wire

/* File: verilog/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_sys_rst,
	input  wire logic         i_clk_en,
	// pins in, agreed level out
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level,
	output logic      [W-1:0] o_rise
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
		logic [W-1:0] rise;
	} sync_t;
	sync_t q;
	sync_t d;

	// level taken only where stages two and three agree
	always_comb
	begin
		d = q;
		d.s1 = i_pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
		d.rise = d.lvl & ~q.lvl;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			q <= '0;
		else if (i_clk_en)
			q <= d;
	end

	assign o_level = q.lvl;
	assign o_rise  = q.rise;
endmodule
`default_nettype wire

/* File: tb/ser_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module ser_partner (
	// control
	input  wire logic                          i_run,
	// serializer side
	output logic                               o_ser_clk,
	input  wire logic [frame_pkg::WORD_W-1:0] i_data,
	input  wire logic                          i_ctrl,
	// collected results
	output logic      [frame_pkg::PAY_W-1:0]  o_payload,
	output int                                 o_blocks,
	output int                                 o_bad
);
	int idx;
	// free clock while running, parked low when stalled
	initial
	begin
		o_ser_clk = 1'b0;
		forever #80 if (i_run || o_ser_clk) o_ser_clk = ~o_ser_clk;
	end
	// collector: words read mid period, blocks rebuilt high word first
	// first rise awaited so the start-up fall of the clock is not read
	initial
	begin
		idx = 0;
		o_blocks = 0;
		o_bad = 0;
		o_payload = '0;
		@(posedge o_ser_clk);
		forever
		begin
			@(negedge o_ser_clk);
			if (i_ctrl)
			begin
				if (idx != 0 || (i_data !== frame_pkg::START_CODE && i_data !== frame_pkg::IDLE_CODE))
					o_bad++;
				if (i_data === frame_pkg::START_CODE)
					idx = 1;
			end
			else if (idx == 0)
				o_bad++;
			else
			begin
				o_payload = {o_payload[79:0], i_data};
				idx = (idx == 6) ? 0 : idx + 1;
				if (idx == 0)
					o_blocks++;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/test_charge_data_frame_packer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_charge_data_frame_packer;
	logic        sys_clk, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        integ, pmark, amark, dvalid, ser_clk, ser_ctrl, run, er;
	logic [55:0] chan;
	logic [1:0]  cap, mode;
	logic [15:0] ser_data;
	logic [95:0] payload;
	logic [13:0] ic0;
	int          blocks, bad, n_fail, compares;
	// ----
	// design and far side
	// ----
	charge_data_frame_packer DUT (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_clk_en(clk_en),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_integration_clock(integ), .i_chan_data(chan), .i_capacitor_index(cap),
		.i_proton_mark(pmark), .i_pbar_mark(amark), .i_int_mode(mode),
		.i_data_valid(dvalid), .i_ser_clk(ser_clk), .o_ser_data(ser_data), .o_ser_ctrl(ser_ctrl));
	ser_partner far (.i_run(run), .o_ser_clk(ser_clk), .i_data(ser_data), .i_ctrl(ser_ctrl),
		.o_payload(payload), .o_blocks(blocks), .o_bad(bad));
	// ----
	// shared tasks
	// ----
	task chk(input string n, input logic [63:0] s, input logic [63:0] e);
		compares++;
		if (s !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pulse(input logic [62:0] v);
		@(posedge sys_clk);
		{pmark, amark, mode, dvalid, cap, chan} <= v;
		repeat (8) @(posedge sys_clk);
		integ <= 1'b1;
		repeat (8) @(posedge sys_clk);
		integ <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask
	task wait_blk(input int n);
		int k;
		for (k = 0; k < 600 && blocks < n; k++)
			@(posedge sys_clk);
		chk("blocks", 64'(blocks), 64'(n));
	endtask
	task wrap_up;
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task test_regs;
		int i;
		for (i = 0; i < 4; i++)
		begin
			apb(1'b0, 12'(i * 4), 32'h0);
			chk("reset value", rd, 0);
			chk("mapped err", er, 0);
		end
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped err", er, 1);
		clk_en <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("frozen ready", pready, 0);
		clk_en <= 1'b1;
		pulse(63'h1234_5678_9ABC_DEF0);
		apb(1'b0, frame_pkg::STATUS_OFS, 32'h0);
		chk("disabled status", rd, 0);
	endtask
	task test_block;
		apb(1'b1, frame_pkg::CTRL_OFS, 32'h1);
		pulse(63'h6D3C_5A96_0F1E_2B47);
		wait_blk(1);
		chk("block data", payload[62:0], 63'h6D3C_5A96_0F1E_2B47);
		chk("block pad", payload[95:85], 0);
		ic0 = payload[76:63];
		apb(1'b0, frame_pkg::BLKCNT_OFS, 32'h0);
		chk("sent count", rd, 1);
	endtask
	task test_overflow;
		run <= 1'b0;
		repeat (30) @(posedge sys_clk);
		pulse(63'h2A55_00FF_7F01_4C33);
		pulse(63'h0F0F_1E1E_2D2D_3C3C);
		apb(1'b0, frame_pkg::STATUS_OFS, 32'h0);
		chk("overflow status", rd, 32'h5);
		apb(1'b0, frame_pkg::DROP_OFS, 32'h0);
		chk("drop count", rd, 1);
		apb(1'b1, frame_pkg::STATUS_OFS, 32'h1);
		apb(1'b0, frame_pkg::STATUS_OFS, 32'h0);
		chk("overflow cleared", rd, 32'h4);
		run <= 1'b1;
		wait_blk(2);
		chk("kept sample", payload[62:0], 63'h2A55_00FF_7F01_4C33);
		chk("cycle counter", payload[76:63], 14'(ic0 + 14'h1));
		apb(1'b1, frame_pkg::CTRL_OFS, 32'h3);
		apb(1'b0, frame_pkg::BLKCNT_OFS, 32'h0);
		chk("cleared count", rd, 0);
		apb(1'b0, frame_pkg::CTRL_OFS, 32'h0);
		chk("ctrl readback", rd, 1);
		chk("link framing", 64'(bad), 0);
	endtask
	// ----
	// clock, watchdog, main sequence
	// ----
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial
	begin
		#200000;
		n_fail++;
		wrap_up;
	end
	initial
	begin
		{sys_rst, clk_en, run} = 3'b111;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{integ, pmark, amark, mode, dvalid, cap, chan} = '0;
		n_fail = 0;
		compares = 0;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		test_regs;
		test_block;
		test_overflow;
		wrap_up;
	end
endmodule
`default_nettype wire
